/* File: pkg/hdae_defs.vh */
// constants for the hall debounce and angle estimator
`ifndef HDAE_DEFS_VH
`define HDAE_DEFS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define HDAE_CLK_PS 32'd10000
`define HDAE_DB_UNIT_PS 32'd10417
`define HDAE_TIMEOUT_TICKS 13'd4096

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define HDAE_REG_CTRL 8'h00
`define HDAE_REG_DEBOUNCE 8'h04
`define HDAE_REG_GAIN 8'h08
`define HDAE_REG_FILT 8'h0C
`define HDAE_REG_OFFSET 8'h10
`define HDAE_REG_STATUS 8'h14
`define HDAE_REG_ANGLE 8'h18
`define HDAE_REG_SPEED 8'h1C
`define HDAE_REG_POS 8'h20

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define HDAE_CTRL_MODE_LSB 0
`define HDAE_CTRL_DIR_BIT 2
`define HDAE_MODE_3DIG 2'h0
`define HDAE_MODE_2DIG 2'h1
`define HDAE_MODE_2ANA 2'h2
`define HDAE_STAT_SECTOR_LSB 4
`define HDAE_STAT_WIDE_BIT 3
`define HDAE_STAT_UNEXP_BIT 1
`define HDAE_STAT_INVAL_BIT 0
`define HDAE_RST_CTRL 16'h0000
`define HDAE_RST_DEBOUNCE 16'h0060
`define HDAE_RST_GAIN 16'h0000
`define HDAE_RST_FILT 16'h1000
`define HDAE_RST_OFFSET 16'h0000

// ----------------------------------------
// angles, 16 bits per turn
// ----------------------------------------
`define HDAE_ANG_15 16'h0AAB
`define HDAE_ANG_30 16'h1555
`define HDAE_ANG_60 16'h2AAB
`define HDAE_ANG_75 16'h3555
`define HDAE_ANG_120 16'h5555
`define HDAE_ANG_150 16'h6AAB

// ----------------------------------------
// speed scaling
// ----------------------------------------
`define HDAE_SPEED_MUL 16'h0100
`define HDAE_SPEED_SHIFT 16

`endif

/* File: core/hdae_core.v */
// hall debounce, pattern validation and angle/speed estimator
`timescale 1ns/1ps
`include "hdae_defs.vh"

module hdae_core (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // sensors and timing
   input wire sensor_input_first_i,
   input wire sensor_input_second_i,
   input wire sensor_input_third_i,
   input wire comp_first_i,
   input wire comp_second_i,
   input wire pwm_tick_i,
   // results
   output reg [15:0] rotor_angle_output_o,
   output reg [15:0] rotor_speed_output_o,
   output reg [2:0] sector_o,
   output reg [31:0] position_o
);

   // ----------------------------------------
   // lookup tables
   // ----------------------------------------
   // pattern to sector, bit 3 of result is the valid flag
   function [3:0] pat2sec;
      input two;
      input [2:0] p;
      begin
         if (two) begin
            case (p[1:0])
               2'h1: pat2sec = 4'hD;
               2'h3: pat2sec = 4'h9;
               2'h2: pat2sec = 4'hA;
               default: pat2sec = 4'hC;
            endcase
         end else begin
            case (p)
               3'h1: pat2sec = 4'h8;
               3'h3: pat2sec = 4'h9;
               3'h2: pat2sec = 4'hA;
               3'h6: pat2sec = 4'hB;
               3'h4: pat2sec = 4'hC;
               3'h5: pat2sec = 4'hD;
               default: pat2sec = 4'h0;
            endcase
         end
      end
   endfunction

   // expected next pattern per direction
   function [2:0] exp_pat;
      input two;
      input ccw;
      input [2:0] s;
      begin
         if (two) begin
            case ({ccw, s})
               4'h5: exp_pat = 3'h3;
               4'h1: exp_pat = 3'h2;
               4'h2: exp_pat = 3'h0;
               4'h4: exp_pat = 3'h1;
               4'hD: exp_pat = 3'h0;
               4'h9: exp_pat = 3'h1;
               4'hA: exp_pat = 3'h3;
               default: exp_pat = 3'h2;
            endcase
         end else begin
            case ({ccw, s})
               4'h0: exp_pat = 3'h3;
               4'h1: exp_pat = 3'h2;
               4'h2: exp_pat = 3'h6;
               4'h3: exp_pat = 3'h4;
               4'h4: exp_pat = 3'h5;
               4'h5: exp_pat = 3'h1;
               4'h8: exp_pat = 3'h5;
               4'h9: exp_pat = 3'h1;
               4'hA: exp_pat = 3'h3;
               4'hB: exp_pat = 3'h2;
               4'hC: exp_pat = 3'h6;
               default: exp_pat = 3'h4;
            endcase
         end
      end
   endfunction

   // byte-lane merge for 16-bit registers
   function [15:0] lane16;
      input [15:0] old;
      input [31:0] dat;
      input [3:0] sel;
      begin
         lane16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
      end
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [15:0] ctrl_q;
   reg [15:0] db_len_q;
   reg [15:0] gain_q;
   reg [15:0] filt_coef_q;
   reg [15:0] offset_q;
   reg [6:0] status_q;

   wire [1:0] mode = ctrl_q[`HDAE_CTRL_MODE_LSB +: 2];
   wire two_mode = (mode != `HDAE_MODE_3DIG);
   wire dir_ccw = ctrl_q[`HDAE_CTRL_DIR_BIT];
   wire loop_on = (gain_q != 16'h0000);
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_q <= `HDAE_RST_CTRL;
         db_len_q <= `HDAE_RST_DEBOUNCE;
         gain_q <= `HDAE_RST_GAIN;
         filt_coef_q <= `HDAE_RST_FILT;
         offset_q <= `HDAE_RST_OFFSET;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && wb_we_i) begin
            case (wb_adr_i)
               `HDAE_REG_CTRL: ctrl_q <= lane16(ctrl_q, wb_dat_i, wb_sel_i);
               `HDAE_REG_DEBOUNCE: db_len_q <= lane16(db_len_q, wb_dat_i, wb_sel_i);
               `HDAE_REG_GAIN: gain_q <= lane16(gain_q, wb_dat_i, wb_sel_i);
               `HDAE_REG_FILT: filt_coef_q <= lane16(filt_coef_q, wb_dat_i, wb_sel_i);
               `HDAE_REG_OFFSET: offset_q <= lane16(offset_q, wb_dat_i, wb_sel_i);
               default: ;
            endcase
         end else if (wb_req) begin
            case (wb_adr_i)
               `HDAE_REG_CTRL: wb_dat_o <= {16'h0000, ctrl_q};
               `HDAE_REG_DEBOUNCE: wb_dat_o <= {16'h0000, db_len_q};
               `HDAE_REG_GAIN: wb_dat_o <= {16'h0000, gain_q};
               `HDAE_REG_FILT: wb_dat_o <= {16'h0000, filt_coef_q};
               `HDAE_REG_OFFSET: wb_dat_o <= {16'h0000, offset_q};
               `HDAE_REG_STATUS: wb_dat_o <= {25'h0000000, status_q};
               `HDAE_REG_ANGLE: wb_dat_o <= {16'h0000, rotor_angle_output_o};
               `HDAE_REG_SPEED: wb_dat_o <= {16'h0000, rotor_speed_output_o};
               `HDAE_REG_POS: wb_dat_o <= position_o;
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // debounce filters
   // ----------------------------------------
   // setting times unit, rounded up to clock cycles
   wire [31:0] db_prod = {16'h0000, db_len_q} * `HDAE_DB_UNIT_PS;
   wire [31:0] db_cycles = (db_prod + `HDAE_CLK_PS - 32'd1) / `HDAE_CLK_PS;
   wire [2:0] raw = {sensor_input_third_i,
                     (mode == `HDAE_MODE_2ANA) ? comp_second_i : sensor_input_second_i,
                     (mode == `HDAE_MODE_2ANA) ? comp_first_i : sensor_input_first_i};
   reg [2:0] last_q;
   reg [2:0] stable_q;
   wire [2:0] stable_d;

   // one process owns the sampled and debounced levels
   always @(posedge clk_i) begin
      if (rst_i) begin
         last_q <= 3'h0;
         stable_q <= 3'h0;
      end else begin
         last_q <= raw;
         stable_q <= stable_d;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_db
         reg [17:0] cnt_q;
         wire settled = ({14'h0000, cnt_q} >= db_cycles);
         assign stable_d[gi] = (raw[gi] == last_q[gi] && raw[gi] != stable_q[gi] && settled)
                               ? raw[gi] : stable_q[gi];
         always @(posedge clk_i) begin
            if (rst_i) begin
               cnt_q <= 18'h00000;
            end else begin
               if (raw[gi] != last_q[gi] || raw[gi] == stable_q[gi] || settled) begin
                  cnt_q <= 18'h00000;
               end else begin
                  cnt_q <= cnt_q + 18'h00001;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // event capture
   // ----------------------------------------
   wire [2:0] used_mask = two_mode ? 3'h3 : 3'h7;
   wire chg = |((stable_d ^ stable_q) & used_mask);
   reg pend_q;
   reg [2:0] pat_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= 1'b0;
         pat_q <= 3'h0;
      end else begin
         pend_q <= chg | (pend_q & ~pwm_tick_i); // new edge beats the clear
         if (chg) begin
            pat_q <= stable_d & used_mask;
         end
      end
   end

   // ----------------------------------------
   // event evaluation
   // ----------------------------------------
   reg [2:0] sec_q;
   reg wide_q;
   reg sec_ok_q;
   reg [12:0] ivl_q;
   reg signed [31:0] est_q;
   reg signed [31:0] gain_acc_q;
   reg signed [31:0] filt_q;
   reg signed [31:0] adj_q;
   reg [15:0] speed_mag;

   wire [12:0] ivl = (ivl_q == 13'h1FFF) ? ivl_q : ivl_q + 13'h0001;
   wire [3:0] map = pat2sec(two_mode, pat_q);
   wire pat_bad = ~map[3];
   wire [2:0] new_sec = map[2:0];
   // two sensors: sectors 5 and 2 span 120 degrees
   wire new_wide = two_mode & ((new_sec == 3'h5) | (new_sec == 3'h2));
   wire pat_unexp = sec_ok_q && (pat_q != exp_pat(two_mode, dir_ccw, sec_q));
   wire valid = pwm_tick_i & pend_q & ~pat_bad & ~pat_unexp;
   wire [15:0] step = wide_q ? `HDAE_ANG_120 : `HDAE_ANG_60;
   wire [15:0] new_w = new_wide ? `HDAE_ANG_120 : `HDAE_ANG_60;
   wire [15:0] sec_start = {13'h0000, new_sec} * `HDAE_ANG_60;
   wire [15:0] actual = dir_ccw ? sec_start + new_w : sec_start;
   wire timeout = (ivl > `HDAE_TIMEOUT_TICKS);
   wire [31:0] raw_mag = {step, 16'h0000} / {19'h00000, ivl};
   wire signed [31:0] raw_rate = timeout ? 32'sh0 : (dir_ccw ? -raw_mag : raw_mag);
   wire signed [32:0] fdiff = {raw_rate[31], raw_rate} - {filt_q[31], filt_q};
   wire signed [49:0] fprod = fdiff * $signed({1'b0, filt_coef_q});
   wire signed [31:0] filt_d = filt_q + fprod[47:16];
   wire signed [15:0] err = est_q[31:16] - actual;
   wire [15:0] err_mag = err[15] ? -err : err;
   wire [15:0] err_lim = new_wide ? `HDAE_ANG_30 : `HDAE_ANG_15;
   // full product width, a concatenation would cut it to 16 bits
   wire [31:0] adj_mul = gain_q * err_mag;
   wire [35:0] adj_prod = {adj_mul, 4'h0};
   wire [35:0] adj_div = adj_prod / {23'h000000, ivl};
   wire signed [31:0] adj_d = err[15] ? -adj_div[31:0] : adj_div[31:0];
   wire signed [31:0] inc = filt_q - adj_q;
   wire signed [31:0] acc_n = gain_acc_q + inc;
   wire [31:0] acc_mag = acc_n[31] ? -acc_n : acc_n;
   wire [15:0] cap = loop_on ? (wide_q ? `HDAE_ANG_150 : `HDAE_ANG_75)
                             : (wide_q ? `HDAE_ANG_120 : `HDAE_ANG_60);
   // magnitude taken at 32 bits before widening
   wire [31:0] filt_mag = filt_q[31] ? -filt_q : filt_q;
   wire [47:0] spd_prod = {16'h0000, filt_mag} * {32'h0000_0000, `HDAE_SPEED_MUL};

   always @* begin
      speed_mag = spd_prod[`HDAE_SPEED_SHIFT +: 16];
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         sec_q <= 3'h0;
         wide_q <= 1'b0;
         sec_ok_q <= 1'b0;
         ivl_q <= 13'h0000;
         est_q <= 32'sh0;
         gain_acc_q <= 32'sh0;
         filt_q <= 32'sh0;
         adj_q <= 32'sh0;
         status_q <= 7'h00;
         position_o <= 32'h0000_0000;
         sector_o <= 3'h0;
         rotor_angle_output_o <= 16'h0000;
         rotor_speed_output_o <= 16'h0000;
      end else if (pwm_tick_i) begin
         rotor_angle_output_o <= est_q[31:16] + offset_q;
         rotor_speed_output_o <= filt_q[31] ? -speed_mag : speed_mag;
         if (pend_q) begin
            status_q[`HDAE_STAT_INVAL_BIT] <= pat_bad;
            status_q[`HDAE_STAT_UNEXP_BIT] <= ~pat_bad & pat_unexp;
         end
         if (valid) begin
            sec_q <= new_sec;
            wide_q <= new_wide;
            sec_ok_q <= 1'b1;
            sector_o <= new_sec;
            status_q[6:4] <= new_sec;
            status_q[`HDAE_STAT_WIDE_BIT] <= new_wide;
            ivl_q <= 13'h0000;
            gain_acc_q <= 32'sh0;
            if (sec_ok_q) begin
               position_o <= dir_ccw ? position_o - (wide_q ? 32'd2 : 32'd1)
                                     : position_o + (wide_q ? 32'd2 : 32'd1);
               filt_q <= filt_d;
            end
            if (!loop_on || !sec_ok_q || err_mag > err_lim) begin
               est_q <= {actual, 16'h0000};
               adj_q <= 32'sh0;
            end else begin
               adj_q <= adj_d;
            end
         end else begin
            ivl_q <= ivl;
            if (acc_mag < {cap, 16'h0000}) begin
               est_q <= est_q + inc;
               gain_acc_q <= acc_n;
            end
         end
      end
   end

endmodule // hdae_core

/* File: verification/hdae_props.sv */
// concurrent checks on the hall estimator ports
`timescale 1ns/1ps
`include "hdae_defs.vh"
module hdae_props (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // bus
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // estimator
   input wire pwm_tick_i,
   input wire [15:0] rotor_angle_output_o,
   input wire [15:0] rotor_speed_output_o,
   input wire [2:0] sector_o,
   input wire [31:0] position_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   chk_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("data without ack");
   chk_reset_clears: assert property (disable iff (1'b0) rst_i |=> position_o == 32'h0
      && sector_o == 3'h0 && !wb_ack_o) else $error("reset state");
   chk_sector_hold: assert property (!pwm_tick_i |=> $stable(sector_o))
      else $error("sector moved off tick");
   chk_result_hold: assert property (!pwm_tick_i |=> $stable(rotor_angle_output_o)
      && $stable(rotor_speed_output_o) && $stable(position_o)) else $error("result moved");
   chk_sector_range: assert property (sector_o <= 3'h5)
      else $error("sector range");
   chk_pos_step: assert property (!$stable(position_o) |-> position_o - $past(position_o)
      inside {32'h1, 32'h2, 32'hFFFFFFFF, 32'hFFFFFFFE}) else $error("position step");
   chk_status_sector: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h14
      |-> wb_dat_o[6:4] == $past(sector_o)) else $error("status sector");
endmodule // hdae_props
bind hdae_core hdae_props u_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .pwm_tick_i(pwm_tick_i), .rotor_angle_output_o(rotor_angle_output_o),
   .rotor_speed_output_o(rotor_speed_output_o), .sector_o(sector_o),
   .position_o(position_o)
);

/* File: verification/hdae_hall_model.sv */
// hall sensor model: digital levels or comparator outputs
`timescale 1ns/1ps
module hdae_hall_model (
   // clock
   input wire clk_i,
   // sensor lines
   output reg [2:0] hall_o,
   output reg [1:0] comp_o
);
   reg analog_q = 1'b0;
   initial hall_o = 3'h0;
   initial comp_o = 2'h0;
   // pattern is {third, second, first}; the line set not picked by analog_q shows the inverse
   task move(input [2:0] p);
      begin
         @(posedge clk_i);
         hall_o <= analog_q ? ~p : p;
         comp_o <= analog_q ? p[1:0] : ~p[1:0];
      end
   endtask
endmodule // hdae_hall_model

/* File: verification/tb_hall_debounce_angle_estimator.sv */
// self-checking bench for the hall estimator
`timescale 1ns/1ps
`include "hdae_defs.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_fail++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module tb_hall_debounce_angle_estimator;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg cyc = 1'b0;
   reg we = 1'b0;
   reg [7:0] adr = 8'h00;
   reg [31:0] wdat = 32'h0;
   reg tick_q = 1'b0;
   wire [31:0] rdat;
   wire ack;
   wire [2:0] hall;
   wire [1:0] comp;
   wire [15:0] angle;
   wire [15:0] speed;
   wire [2:0] sector;
   wire [31:0] pos;
   integer n_fail = 0;
   integer cmp_count = 0;
   integer i;
   reg [31:0] rd;
   reg [31:0] p0;
   localparam [17:0] CW3 = {3'h3, 3'h2, 3'h6, 3'h4, 3'h5, 3'h1};
   localparam [8:0] PAT2 = {3'h7, 3'h6, 3'h4};
   localparam [8:0] SEC2 = {3'h1, 3'h2, 3'h4};
   localparam [8:0] POS2 = {3'h2, 3'h3, 3'h5};
   always #5 clk_i = ~clk_i;
   hdae_hall_model hm (.clk_i(clk_i), .hall_o(hall), .comp_o(comp));
   hdae_core uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h3), .wb_dat_o(rdat), .wb_ack_o(ack),
      .sensor_input_first_i(hall[0]), .sensor_input_second_i(hall[1]),
      .sensor_input_third_i(hall[2]), .comp_first_i(comp[0]), .comp_second_i(comp[1]),
      .pwm_tick_i(tick_q), .rotor_angle_output_o(angle), .rotor_speed_output_o(speed),
      .sector_o(sector), .position_o(pos)
   );
   task final_report;
      begin
         $display("compares %0d mismatches %0d", cmp_count, n_fail);
         if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d);
      integer k;
      begin
         @(posedge clk_i);
         cyc <= 1'b1;
         we <= w;
         adr <= a;
         wdat <= d;
         k = 0;
         @(posedge clk_i);
         while (ack !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk_i);
         end
         rd = rdat;
         cyc <= 1'b0;
         if (k == 20) begin
            n_fail++;
            final_report;
         end
      end
   endtask
   task tick(input integer n);
      repeat (n) begin
         @(posedge clk_i);
         tick_q <= 1'b1;
         @(posedge clk_i);
         tick_q <= 1'b0;
      end
      @(posedge clk_i);
   endtask
   task step(input [2:0] p);
      hm.move(p);
      repeat (20) @(posedge clk_i);
      tick(1);
   endtask
   task do_reset(input [2:0] p, input [1:0] m);
      hm.analog_q = (m == `HDAE_MODE_2ANA);
      hm.move(p);
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b1, `HDAE_REG_CTRL, {30'h0, m});
      bus(1'b1, `HDAE_REG_DEBOUNCE, 32'hA);
   endtask
   task t_regs;
      bus(1'b0, `HDAE_REG_DEBOUNCE, 32'h0);
      `CHK("debounce", {16'h0, `HDAE_RST_DEBOUNCE}, rd)
      bus(1'b1, `HDAE_REG_GAIN, 32'h800);
      bus(1'b0, `HDAE_REG_GAIN, 32'h0);
      `CHK("gain", 32'h800, rd)
      bus(1'b1, `HDAE_REG_STATUS, 32'hFF);
      bus(1'b0, `HDAE_REG_STATUS, 32'h0);
      `CHK("status", 32'h0, rd)
      bus(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      bus(1'b1, `HDAE_REG_GAIN, 32'h0);
      bus(1'b1, `HDAE_REG_DEBOUNCE, 32'hA);
   endtask
   task t_walk3;
      step(3'h1);
      p0 = pos;
      for (i = 0; i < 6; i++) begin
         step(CW3[17 - 3 * i -: 3]);
         `CHK("sector", (i + 1) % 6, sector)
         `CHK("position", p0 + i + 1, pos)
      end
      bus(1'b0, `HDAE_REG_STATUS, 32'h0);
      `CHK("status", 4'h0, rd[6:3])
   endtask
   task t_bad;
      step(3'h7);
      step(3'h0);
      bus(1'b0, `HDAE_REG_STATUS, 32'h0);
      `CHK("invalid", 2'h1, rd[1:0])
      step(3'h4);
      bus(1'b0, `HDAE_REG_STATUS, 32'h0);
      `CHK("unexpected", 2'h2, rd[1:0])
      `CHK("sector kept", 3'h0, sector)
      `CHK("position kept", p0 + 6, pos)
      step(3'h3);
      `CHK("resumed", 3'h1, sector)
   endtask
   task t_ccw;
      bus(1'b1, `HDAE_REG_CTRL, 32'h4);
      step(3'h1);
      step(3'h5);
      `CHK("ccw sector", 3'h5, sector)
      `CHK("ccw position", p0 + 5, pos)
   endtask
   task t_deb;
      bus(1'b1, `HDAE_REG_DEBOUNCE, 32'h28);
      hm.move(3'h4);
      repeat (25) @(posedge clk_i);
      tick(1);
      `CHK("early", 3'h5, sector)
      repeat (30) @(posedge clk_i);
      tick(1);
      `CHK("late", 3'h4, sector)
      bus(1'b1, `HDAE_REG_DEBOUNCE, 32'hA);
      hm.move(3'h6);
      repeat (6) @(posedge clk_i);
      hm.move(3'h4);
      repeat (2) @(posedge clk_i);
      hm.move(3'h6);
      repeat (4) @(posedge clk_i);
      tick(1);
      `CHK("restart", 3'h4, sector)
      step(3'h6);
      `CHK("settled", 3'h3, sector)
   endtask
   task t_two(input [1:0] m);
      do_reset(3'h0, m);
      step(3'h5);
      `CHK("first wide", 3'h5, sector)
      p0 = pos;
      for (i = 0; i < 3; i++) begin
         step(PAT2[8 - 3 * i -: 3]);
         `CHK("sector", SEC2[8 - 3 * i -: 3], sector)
         `CHK("position", p0 + POS2[8 - 3 * i -: 3], pos)
         bus(1'b0, `HDAE_REG_STATUS, 32'h0);
         `CHK("wide", i == 1, rd[3])
      end
   endtask
   task t_angle;
      do_reset(3'h0, `HDAE_MODE_3DIG);
      bus(1'b1, `HDAE_REG_OFFSET, 32'h100);
      bus(1'b1, `HDAE_REG_FILT, 32'hFFFF);
      step(3'h1);
      tick(4200);
      `CHK("offset", 16'h0100, angle)
      step(3'h3);
      tick(1);
      `CHK("snap", 16'h2BAB, angle)
      step(3'h2);
      tick(20);
      `CHK("capped", 16'h8100, angle)
      `CHK("moving", 1'b1, speed != 16'h0)
      tick(4200);
      step(3'h6);
      tick(4200);
      step(3'h4);
      tick(1);
      `CHK("stalled", 16'h0, speed)
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_walk3;
      t_bad;
      t_ccw;
      t_deb;
      t_two(`HDAE_MODE_2DIG);
      t_two(`HDAE_MODE_2ANA);
      t_angle;
      final_report;
   end
endmodule // tb_hall_debounce_angle_estimator
